// ---- hw/rwq_result_write_queue.sv ----
/*
 * result write queue with hazard comparison stores and forwarding distance.
 * assumes synchronous inputs on clock, a sequencer that keeps schedule
 * requests up while stall_clocks_q is high, and an arithmetic unit that only
 * takes released entries.
 */
`timescale 1ns/1ps
// Summary of operation
// - queue holds sixteen pending result destinations
// - entry keeps addresses, cache or register target, and cache position
// - each produced result reads the next entry in order
// - comparison store written same cycle and slot as the queue entry
// - released addresses, and unreleased ones when compare-pending is set, compared in parallel with operand reads; match means stale
// - five-bit scheduled count plus read and write pointers
// - five-bit unreleased count minus one, and compare-pending flag
// - one schedule request uses exactly one entry
// - schedule into a full queue stops the clocks until room
// - index, register, cache sections written together; type picks valid part
// - one register comparison set per operand on its double-word address
// - eight-bit quarter-word mask from low register bits and precision
// - precision two bits quarter to double; format four bits
// - any index match stalls indexing stage; never forwarded
// - cache write stores even and odd quad-word block high addresses
// - sixteen-bit occupancy per block gives overlap; high address gives match
// - exact match needs low, high and format equal with enables set
// - forward only with exact and no partial; partial stops clocks
// - register comparison same as cache but double-word granular
// - exact lines rotated to age order, priority-encoded to newest distance
module rwq_result_write_queue
(
    input  wire logic                                 clock,
    input  wire logic                                 nrst,
    input  wire logic                                 clk_en,
    input  wire logic                                 sched_valid,
    input  wire logic                                 sched_is_cache,
    input  wire logic                                 sched_release_all,
    input  wire logic                                 cmp_pending_wr,
    input  wire logic                                 cmp_pending_val,
    input  wire logic [rwq_pkg::REG_ADR_W-1:0]        sched_reg_adr,
    input  wire logic [rwq_pkg::REG_LOW_W-1:0]        sched_reg_low,
    input  wire logic [rwq_pkg::PREC_W-1:0]           sched_prec,
    input  wire logic [rwq_pkg::FMT_W-1:0]            sched_fmt,
    input  wire logic [rwq_pkg::IDX_ADR_W-1:0]        sched_idx_adr,
    input  wire logic [rwq_pkg::CADR_W-1:0]           sched_cache_adr,
    input  wire logic [rwq_pkg::LEN_W-1:0]            sched_cache_len,
    input  wire logic [rwq_pkg::POS_W-1:0]            sched_cache_pos,
    input  wire logic                                 result_take,
    input  wire logic [1:0]                           rd_reg_valid,
    input  wire logic [1:0][rwq_pkg::REG_ADR_W-1:0]   rd_reg_adr,
    input  wire logic [1:0][rwq_pkg::REG_LOW_W-1:0]   rd_reg_low,
    input  wire logic [1:0][rwq_pkg::PREC_W-1:0]      rd_prec,
    input  wire logic [1:0][rwq_pkg::FMT_W-1:0]       rd_fmt,
    input  wire logic [1:0]                           rd_cache_valid,
    input  wire logic [1:0][rwq_pkg::CADR_W-1:0]      rd_cache_adr,
    input  wire logic [1:0][rwq_pkg::LEN_W-1:0]       rd_cache_len,
    input  wire logic [1:0]                           idx_valid,
    input  wire logic [1:0][rwq_pkg::IDX_ADR_W-1:0]   idx_adr,
    output logic                                      res_valid_q,
    output logic                                      res_is_cache_q,
    output logic [rwq_pkg::REG_ADR_W-1:0]             res_reg_adr_q,
    output logic [rwq_pkg::REG_QW-1:0]                res_reg_mask_q,
    output logic [rwq_pkg::CADR_W-1:0]                res_cache_adr_q,
    output logic [rwq_pkg::POS_W-1:0]                 res_cache_pos_q,
    output logic [rwq_pkg::CNT_W-1:0]                 scheduled_write_count_q,
    output logic [rwq_pkg::CNT_W-1:0]                 unreleased_m1_q,
    output logic                                      compare_pending_enable_q,
    output logic [rwq_pkg::PTR_W-1:0]                 rd_ptr_q,
    output logic [rwq_pkg::PTR_W-1:0]                 wr_ptr_q,
    output logic                                      stall_clocks_q,
    output logic                                      stall_index_q,
    output logic [1:0]                                op_stale_q,
    output logic [1:0][1:0]                           op_action_q,
    output logic [1:0][rwq_pkg::DIST_W-1:0]           op_fwd_dist_q
);
    import rwq_pkg::*;

    // =========================================================
    // helpers
    // mask within one double word; a run past the top is clipped
    function automatic logic [REG_QW-1:0] reg_mask(input logic [REG_LOW_W-1:0] low,
                                                   input logic [PREC_W-1:0]    prec);
        logic [2*REG_QW-1:0] run;
        run = (2*REG_QW)'((17'h1 << (4'h1 << prec)) - 17'h1);
        return run[REG_QW-1:0] << low;
    endfunction

    // split an unaligned access over its even and odd quad-word blocks
    function automatic rwq_blk_s blocks(input logic [CADR_W-1:0] adr,
                                        input logic [LEN_W-1:0]  len);
        logic [2*QB_QW-1:0] occ;
        logic [BLK_W-1:0]   blk;
        logic [BLK_W-1:0]   nxt;
        rwq_blk_s           b;
        occ = (2*QB_QW)'((33'h1 << len) - 33'h1) << adr[QLOW_W-1:0];
        blk = adr[CADR_W-1:QLOW_W];
        nxt = blk + BLK_W'(1);
        if (blk[0]) begin
            b.odd_hi  = blk[BLK_W-1:1];
            b.odd_v   = occ[QB_QW-1:0];
            b.even_hi = nxt[BLK_W-1:1];
            b.even_v  = occ[2*QB_QW-1:QB_QW];
        end else begin
            b.even_hi = blk[BLK_W-1:1];
            b.even_v  = occ[QB_QW-1:0];
            b.odd_hi  = blk[BLK_W-1:1];
            b.odd_v   = occ[2*QB_QW-1:QB_QW];
        end
        return b;
    endfunction

    // highest set position, i.e. newest in age order
    function automatic logic [PTR_W-1:0] newest(input logic [RWQ_DEPTH-1:0] v);
        logic [PTR_W-1:0] k;
        k = PTR_ZERO;
        for (int i = 0; i < RWQ_DEPTH; i++) begin
            if (v[i]) begin
                k = PTR_W'(i);
            end
        end
        return k;
    endfunction

    // =========================================================
    // occupancy bookkeeping
    logic [CNT_W-1:0] released_cnt;
    logic             q_full;
    logic             sched_ok;
    logic             take_ok;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] unrel_d;
    logic             cmp_en_d;
    rwq_blk_s         wblk;

    // minus-one form makes all ones mean nothing unreleased
    assign released_cnt = CNT_W'(scheduled_write_count_q - unreleased_m1_q - CNT_ONE);
    assign q_full       = (scheduled_write_count_q == CNT_FULL);
    assign sched_ok     = sched_valid & ~q_full;
    assign take_ok      = result_take & (released_cnt != CNT_ZERO);
    assign cnt_d        = CNT_W'(scheduled_write_count_q + {4'h0, sched_ok}
                                 - {4'h0, take_ok});
    // release also covers an entry scheduled in the same cycle
    assign unrel_d      = sched_release_all ? UNREL_NONE
                        : sched_ok ? CNT_W'(unreleased_m1_q + CNT_ONE)
                        : unreleased_m1_q;
    assign cmp_en_d     = cmp_pending_wr ? cmp_pending_val : compare_pending_enable_q;
    assign wblk         = blocks(sched_cache_adr, sched_cache_len);

    // control state; all of it holds while clk_en is low
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scheduled_write_count_q  <= CNT_ZERO;
            unreleased_m1_q          <= UNREL_NONE;
            compare_pending_enable_q <= 1'b0;
            rd_ptr_q                 <= PTR_ZERO;
            wr_ptr_q                 <= PTR_ZERO;
        end else if (clk_en) begin
            scheduled_write_count_q  <= cnt_d;
            unreleased_m1_q          <= unrel_d;
            compare_pending_enable_q <= cmp_en_d;
            rd_ptr_q                 <= rd_ptr_q + (take_ok ? PTR_ONE : PTR_ZERO);
            wr_ptr_q                 <= wr_ptr_q + (sched_ok ? PTR_ONE : PTR_ZERO);
        end
    end

    // =========================================================
    // queue entries and comparison stores, one slot per entry
    logic                      e_cache_q [RWQ_DEPTH];
    logic [REG_ADR_W-1:0]      e_radr_q  [RWQ_DEPTH];
    logic [REG_LOW_W-1:0]      e_rlow_q  [RWQ_DEPTH];
    logic [REG_QW-1:0]         e_rmask_q [RWQ_DEPTH];
    logic [FMT_W+PREC_W-1:0]   e_fmtp_q  [RWQ_DEPTH];
    logic [IDX_ADR_W-1:0]      e_idx_q   [RWQ_DEPTH];
    logic [CADR_W-1:0]         e_cadr_q  [RWQ_DEPTH];
    logic [LEN_W-1:0]          e_len_q   [RWQ_DEPTH];
    logic [POS_W-1:0]          e_pos_q   [RWQ_DEPTH];
    rwq_blk_s                  e_blk_q   [RWQ_DEPTH];

    // data only, no reset: the age window keeps stale slots out of compares
    always_ff @(posedge clock) begin
        if (clk_en && sched_ok) begin
            e_cache_q[wr_ptr_q] <= sched_is_cache;
            e_radr_q[wr_ptr_q]  <= sched_reg_adr;
            e_rlow_q[wr_ptr_q]  <= sched_reg_low;
            e_rmask_q[wr_ptr_q] <= reg_mask(sched_reg_low, sched_prec);
            e_fmtp_q[wr_ptr_q]  <= {sched_fmt, sched_prec};
            e_idx_q[wr_ptr_q]   <= sched_idx_adr;
            e_cadr_q[wr_ptr_q]  <= sched_cache_adr;
            e_len_q[wr_ptr_q]   <= sched_cache_len;
            e_pos_q[wr_ptr_q]   <= sched_cache_pos;
            e_blk_q[wr_ptr_q]   <= wblk;
        end
    end

    // =========================================================
    // parallel comparison of every slot against both operands
    logic [1:0][RWQ_DEPTH-1:0] exact;
    logic [1:0][RWQ_DEPTH-1:0] part;
    logic [1:0][RWQ_DEPTH-1:0] idx_hit;
    logic [1:0][RWQ_DEPTH-1:0] rot;
    rwq_blk_s                  rblk  [NOPS];
    logic [REG_QW-1:0]         rmask [NOPS];

    generate
        for (genvar o = 0; o < NOPS; o++) begin : g_op
            assign rblk[o]  = blocks(rd_cache_adr[o], rd_cache_len[o]);
            assign rmask[o] = reg_mask(rd_reg_low[o], rd_prec[o]);
        end
        for (genvar e = 0; e < RWQ_DEPTH; e++) begin : g_ent
            wire [PTR_W-1:0] age    = PTR_W'(e) - rd_ptr_q;
            wire             in_use = {1'b0, age} < scheduled_write_count_q;
            wire             in_rel = {1'b0, age} < released_cnt;
            // unreleased slots only join the compare when enabled
            wire             cmp_ok = in_rel | (in_use & compare_pending_enable_q);
            wire             r_vld  = cmp_ok & ~e_cache_q[e];
            wire             c_vld  = cmp_ok & e_cache_q[e];
            for (genvar o = 0; o < NOPS; o++) begin : g_cmp
                // double-word granular register compare
                wire r_hi  = r_vld & (e_radr_q[e] == rd_reg_adr[o]);
                wire r_ov  = r_hi & (|(e_rmask_q[e] & rmask[o]));
                wire r_ex  = r_hi & (e_rlow_q[e] == rd_reg_low[o])
                           & (e_fmtp_q[e] == {rd_fmt[o], rd_prec[o]});
                // quad-word block compare, either block may carry overlap
                wire c_ev  = (e_blk_q[e].even_hi == rblk[o].even_hi)
                           & (|(e_blk_q[e].even_v & rblk[o].even_v));
                wire c_od  = (e_blk_q[e].odd_hi == rblk[o].odd_hi)
                           & (|(e_blk_q[e].odd_v & rblk[o].odd_v));
                wire c_ov  = c_vld & (c_ev | c_od);
                wire c_ex  = c_vld & (e_cadr_q[e] == rd_cache_adr[o])
                           & (e_len_q[e] == rd_cache_len[o])
                           & (e_fmtp_q[e] == {rd_fmt[o], rd_prec[o]});
                assign exact[o][e]   = (rd_reg_valid[o] & r_ov & r_ex)
                                     | (rd_cache_valid[o] & c_ex);
                assign part[o][e]    = (rd_reg_valid[o] & r_ov & ~r_ex)
                                     | (rd_cache_valid[o] & c_ov & ~c_ex);
                assign idx_hit[o][e] = r_vld & idx_valid[o]
                                     & (e_idx_q[e] == idx_adr[o]);
                // position k holds the slot scheduled k-th after the oldest
                assign rot[o][e]     = exact[o][PTR_W'(rd_ptr_q + PTR_W'(e))];
            end
        end
    endgenerate

    // =========================================================
    // hazard decision per operand
    logic [1:0]              any_part;
    logic [1:0]              any_exact;
    logic [1:0][1:0]         act_d;
    logic [1:0][DIST_W-1:0]  dist_d;
    logic                    stall_clk_d;
    logic                    stall_idx_d;

    generate
        for (genvar o = 0; o < NOPS; o++) begin : g_dec
            assign any_part[o]  = |part[o];
            assign any_exact[o] = |exact[o];
            // any partial match anywhere blocks forwarding; slightly pessimistic
            assign act_d[o]  = any_part[o] ? RWQ_ACT_STALL
                             : any_exact[o] ? RWQ_ACT_FORWARD : RWQ_ACT_READ;
            // zero means the most recently scheduled write
            assign dist_d[o] = DIST_W'(scheduled_write_count_q - CNT_ONE
                                      - {1'b0, newest(rot[o])});
        end
    endgenerate
    assign stall_clk_d = (sched_valid & q_full) | (|any_part);
    assign stall_idx_d = |idx_hit;

    // registered hazard outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stall_clocks_q <= 1'b0;
            stall_index_q  <= 1'b0;
            op_stale_q     <= '0;
            op_action_q    <= '0;
            op_fwd_dist_q  <= '0;
        end else if (clk_en) begin
            stall_clocks_q <= stall_clk_d;
            stall_index_q  <= stall_idx_d;
            op_stale_q     <= any_part | any_exact;
            op_action_q    <= act_d;
            op_fwd_dist_q  <= dist_d;
        end
    end

    // =========================================================
    // destination of the result being produced, read in order
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            res_valid_q     <= 1'b0;
            res_is_cache_q  <= 1'b0;
            res_reg_adr_q   <= '0;
            res_reg_mask_q  <= '0;
            res_cache_adr_q <= '0;
            res_cache_pos_q <= '0;
        end else if (clk_en) begin
            res_valid_q <= take_ok;
            if (take_ok) begin
                res_is_cache_q  <= e_cache_q[rd_ptr_q];
                res_reg_adr_q   <= e_radr_q[rd_ptr_q];
                res_reg_mask_q  <= e_rmask_q[rd_ptr_q];
                res_cache_adr_q <= e_cadr_q[rd_ptr_q];
                res_cache_pos_q <= e_pos_q[rd_ptr_q];
            end
        end
    end

    // =========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_count_bound;
        scheduled_write_count_q <= CNT_FULL;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("queue count above 16");
    property p_one_entry;
        clk_en && sched_ok && !take_ok |=>
            scheduled_write_count_q == $past(scheduled_write_count_q) + CNT_ONE;
    endproperty
    a_one_entry: assert property (p_one_entry) else $error("schedule not one entry");
    property p_wr_ptr;
        clk_en && sched_ok |=> wr_ptr_q == PTR_W'($past(wr_ptr_q) + PTR_ONE);
    endproperty
    a_wr_ptr: assert property (p_wr_ptr) else $error("write pointer not advanced");
    property p_full_stop;
        clk_en && sched_valid && q_full |=> stall_clocks_q && $stable(wr_ptr_q);
    endproperty
    a_full_stop: assert property (p_full_stop) else $error("overflow not stopped");
    property p_release;
        clk_en && sched_release_all |=> unreleased_m1_q == UNREL_NONE
            && released_cnt == scheduled_write_count_q;
    endproperty
    a_release: assert property (p_release) else $error("release all left entries");
    property p_index_stall;
        clk_en && (|idx_hit) |=> stall_index_q;
    endproperty
    a_index_stall: assert property (p_index_stall) else $error("index match no stall");
    property p_partial;
        clk_en && any_part[0] |=> stall_clocks_q && op_action_q[0] == RWQ_ACT_STALL;
    endproperty
    a_partial: assert property (p_partial) else $error("partial match not stalled");

    property p_mask;
        rd_reg_valid[0] && rd_reg_low[0] == '0 |->
            $countones(rmask[0]) == (4'h1 << rd_prec[0]) && rmask[0][0];
    endproperty
    a_mask: assert property (p_mask) else $error("quarter-word mask wrong");

    property p_result;
        clk_en && take_ok |=> res_valid_q && res_is_cache_q == $past(e_cache_q[rd_ptr_q])
            && rd_ptr_q == PTR_W'($past(rd_ptr_q) + PTR_ONE);
    endproperty
    a_result: assert property (p_result) else $error("result entry not in order");

    property p_forward;
        clk_en && any_exact[1] && !any_part[1] |=> op_action_q[1] == RWQ_ACT_FORWARD
            && op_stale_q[1];
    endproperty
    a_forward: assert property (p_forward) else $error("exact match not forwarded");

    c_full:    cover property (clk_en && sched_valid && q_full);
    c_forward: cover property (op_action_q[0] == RWQ_ACT_FORWARD);
    c_partial: cover property (op_action_q[1] == RWQ_ACT_STALL);
    c_index:   cover property (stall_index_q);
endmodule

// ---- hw/rwq_pkg.sv ----
/*
 * constants, encodings and the cache-block record for the result write queue.
 * assumes nothing of its surroundings; imported by the queue module.
 */
package rwq_pkg;
    // =========================================================
    // queue geometry
    localparam int RWQ_DEPTH = 16;
    localparam int PTR_W     = 4;
    localparam int CNT_W     = 5;
    localparam int NOPS      = 2;
    localparam int DIST_W    = 4;
    // =========================================================
    // address and field widths
    localparam int REG_ADR_W = 6;   // double-word register address
    localparam int REG_LOW_W = 3;   // quarter word inside a double word
    localparam int REG_QW    = 8;   // quarter words per double word
    localparam int IDX_ADR_W = 5;
    localparam int CADR_W    = 24;  // quarter-word cache address
    localparam int QLOW_W    = 4;   // quarter word inside a quad word
    localparam int QB_QW     = 16;  // quarter words per quad-word block
    localparam int BLK_W     = CADR_W - QLOW_W;
    localparam int PAIR_W    = BLK_W - 1;
    localparam int LEN_W     = 5;   // 1..16 quarter words
    localparam int POS_W     = 8;   // cache position of the write
    localparam int FMT_W     = 4;
    localparam int PREC_W    = 2;
    // =========================================================
    // reset and step values
    localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
    localparam logic [CNT_W-1:0] CNT_FULL   = 5'h10;
    localparam logic [CNT_W-1:0] UNREL_NONE = 5'h1f; // zero unreleased, minus one
    localparam logic [PTR_W-1:0] PTR_ZERO   = 4'h0;
    localparam logic [PTR_W-1:0] PTR_ONE    = 4'h1;
    // =========================================================
    // encodings
    typedef enum logic [PREC_W-1:0] {
        RWQ_PREC_QUARTER = 2'b00,
        RWQ_PREC_HALF    = 2'b01,
        RWQ_PREC_SINGLE  = 2'b10,
        RWQ_PREC_DOUBLE  = 2'b11
    } rwq_prec_e;
    typedef enum logic [1:0] {
        RWQ_ACT_READ    = 2'b00,
        RWQ_ACT_FORWARD = 2'b01,
        RWQ_ACT_STALL   = 2'b11
    } rwq_act_e;
    typedef struct packed {
        logic [PAIR_W-1:0] even_hi;
        logic [PAIR_W-1:0] odd_hi;
        logic [QB_QW-1:0]  even_v;
        logic [QB_QW-1:0]  odd_v;
    } rwq_blk_s;
endpackage

// ---- test/rwq_arith_model.sv ----
/* arithmetic-unit stand-in that consumes queued results on request.
   assumes the bench changes want away from the rising edge. */
`timescale 1ns/1ps
module rwq_arith_model (
    input  wire logic clock,
    input  wire logic want,
    output logic      result_take
);
    // ==========================================
    // take pulse: one cycle, so each request consumes one entry
    initial result_take = 1'b0;
    // launched on the rising edge by non-blocking update, so the queue sees it one edge later
    always @(posedge clock) begin
        result_take <= want & ~result_take;
    end
endmodule

// ---- test/tb.sv ----
/* scenario bench for the result write queue.
   assumes rwq_pkg and the arithmetic-unit stand-in are compiled first. */
`timescale 1ns/1ps
module tb
    import rwq_pkg::*;
;
    // ==========================================
    // stimulus and observed signals
    logic clock, nrst, ce, want, take, sv, sc, rel, cw, cv, res_valid_q, res_is_cache_q;
    logic compare_pending_enable_q, stall_clocks_q, stall_index_q;
    logic [5:0] sra, res_reg_adr_q;
    logic [2:0] srl;
    logic [1:0] sp, rv, rcv, iv, op_stale_q;
    logic [3:0] sf, rd_ptr_q, wr_ptr_q;
    logic [4:0] sia, scl, scheduled_write_count_q, unreleased_m1_q;
    logic [23:0] sca, res_cache_adr_q;
    logic [7:0] scp, res_reg_mask_q, res_cache_pos_q;
    logic [1:0][5:0] ra;
    logic [1:0][2:0] rl;
    logic [1:0][1:0] rp, op_action_q;
    logic [1:0][3:0] rf, op_fwd_dist_q;
    logic [1:0][23:0] rca;
    logic [1:0][4:0] rcl, ia;
    int num_errors = 0;
    int checked = 0;
    // ==========================================
    // block under test and its consumer; clock enable held on except for one step in t_cache
    rwq_result_write_queue rwq_result_write_queue_i (
        .clock, .nrst, .clk_en(ce), .sched_valid(sv), .sched_is_cache(sc),
        .sched_release_all(rel), .cmp_pending_wr(cw), .cmp_pending_val(cv),
        .sched_reg_adr(sra), .sched_reg_low(srl), .sched_prec(sp), .sched_fmt(sf),
        .sched_idx_adr(sia), .sched_cache_adr(sca), .sched_cache_len(scl),
        .sched_cache_pos(scp), .result_take(take), .rd_reg_valid(rv), .rd_reg_adr(ra),
        .rd_reg_low(rl), .rd_prec(rp), .rd_fmt(rf), .rd_cache_valid(rcv),
        .rd_cache_adr(rca), .rd_cache_len(rcl), .idx_valid(iv), .idx_adr(ia),
        .res_valid_q, .res_is_cache_q, .res_reg_adr_q, .res_reg_mask_q, .res_cache_adr_q,
        .res_cache_pos_q, .scheduled_write_count_q, .unreleased_m1_q,
        .compare_pending_enable_q, .rd_ptr_q, .wr_ptr_q, .stall_clocks_q, .stall_index_q,
        .op_stale_q, .op_action_q, .op_fwd_dist_q);
    rwq_arith_model rwq_arith_model_i (.clock, .want, .result_take(take));
    // ==========================================
    // helpers
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios: fill past full, compare, take, cache write
    task automatic t_fill;
        chk(unreleased_m1_q, 5'h1f);
        {sv, cw, cv, sra, sp, sf, sia} = {3'b111, 6'h05, RWQ_PREC_SINGLE, 4'h3, 5'h07};
        step(1);
        chk({compare_pending_enable_q, unreleased_m1_q, wr_ptr_q}, 10'h201);
        {cw, rel} = 2'b01;
        step(15);
        chk({scheduled_write_count_q, unreleased_m1_q}, 10'h21f);
        step(1);
        chk({stall_clocks_q, scheduled_write_count_q}, 6'h30);
        {sv, rel} = 2'b00;
    endtask
    task automatic t_cmp;
        {rv, ra, rp, rf, iv, ia[1]} = {2'b11, 12'h145, 4'ha, 8'h33, 2'b10, 5'h07};
        rl[1] = 3'h1;
        step(1);
        chk({op_stale_q, op_action_q, op_fwd_dist_q[0]}, 10'h3d0);
        chk({stall_clocks_q, stall_index_q}, 2'b11);
        {rv, iv, rf[0]} = {4'b0100, 4'h4};
        step(1);
        chk(op_action_q[0], RWQ_ACT_STALL);
        {rv, rl[1], rf[0]} = {2'b00, 3'h0, 4'h3};
    endtask
    task automatic t_take;
        want = 1'b1;
        step(1);
        want = 1'b0;
        step(1);
        chk({res_valid_q, res_is_cache_q, res_reg_adr_q, res_reg_mask_q}, 16'h850f);
        chk({rd_ptr_q, scheduled_write_count_q}, 9'h02f);
    endtask
    task automatic t_cache;
        {ce, sv, sc, rel, sca, scl, scp} = {4'b0111, 24'h000042, 5'd4, 8'h09};
        step(1);
        chk({wr_ptr_q, scheduled_write_count_q}, 9'h00f);
        ce = 1'b1;
        step(1);
        {sv, sc, rel, rv, rcv, rca[0], rcl[0]} = {7'b0001001, 24'h000042, 5'd4};
        step(1);
        chk({op_action_q, op_fwd_dist_q}, 12'h510);
        chk(scheduled_write_count_q, 5'h10);
    endtask
    // drain in order until the cache entry comes out, bounded
    task automatic t_drain;
        int n;
        {rv, rcv, want} = 5'b00001;
        n = 0;
        while (n < 40 && !(res_valid_q && res_is_cache_q)) begin
            step(1);
            n++;
        end
        want = 1'b0;
        if (n == 40) begin
            num_errors++;
        end
        chk({res_cache_adr_q, res_cache_pos_q}, 32'h00004209);
        chk({rd_ptr_q, scheduled_write_count_q}, 9'h020);
    endtask
    // ==========================================
    // main sequence and hang guard
    initial begin
        {sv, sc, rel, cw, cv, want, sra, srl, sp, sf, sia, sca, scl, scp} = '0;
        {rv, rcv, iv, ra, rl, rp, rf, rca, rcl, ia} = '0;
        nrst = 1'b0;
        ce = 1'b1;
        step(4);
        nrst = 1'b1;
        t_fill();
        t_cmp();
        t_take();
        t_cache();
        t_drain();
        test_done();
    end
    initial begin
        repeat (3000) @(posedge clock);
        num_errors++;
        test_done();
    end
endmodule
